// [verilog/esr_pkg.sv]
// Constants for the egress shaping and rate limiting block
package esr_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_IRATE = 8'h04;
    localparam logic [7:0] A_ERATE = 8'h08;
    localparam logic [7:0] A_SLOPE = 8'h0C;
    localparam logic [7:0] A_TIDX = 8'h10;
    localparam logic [7:0] A_TDATA = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam int C_IEN = 0;
    localparam int C_EEN = 1;
    localparam int C_S100 = 2;
    localparam int C_IFG = 3;
    localparam int C_PRE = 4;
    localparam int C_CLS = 5;
    localparam int C_FOURQ = 7;
    localparam int C_WRR = 8;
    localparam int C_GEN = 9;
    localparam int C_GQ = 10;
    localparam int C_CBS = 12;
    localparam int C_CT = 14;
    localparam int C_SET = 15;
    localparam int C_FC = 20;
    localparam logic [20:0] CTRL_RST = 21'h000000;
    localparam logic [1:0] K_ALL = 2'h0;
    localparam logic [14:0] IFG_BYTES = 15'h000C;
    localparam logic [14:0] PRE_BYTES = 15'h0008;
    localparam logic [13:0] CT_BYTES = 14'h0040;
    localparam logic [7:0] LIM10 = 8'h0A;
    localparam logic [7:0] LIM100 = 8'h64;
    localparam logic [9:0] BYTE_NS_10 = 10'h320;
    localparam logic [9:0] BYTE_NS_100 = 10'h050;
    localparam int CLK_NS = 4;
    localparam int TICK_NS = 1000;
    localparam logic [7:0] TICK_CYC = 8'(TICK_NS / CLK_NS);
    localparam logic signed [20:0] BKT_CAP = 21'sh00FFFF;
    localparam logic [1:0] E_PER = 2'h0;
    localparam logic [1:0] E_GRD = 2'h1;
    localparam logic [1:0] E_WIN = 2'h2;
    typedef enum logic [1:0] {G_OPEN, G_GUARD, G_WIN} esr_gate_type;
endpackage

// [verilog/esr_egress_shaping_rate_limiter.sv]
// Per-port rate limiters, credit shaper, time window gate, cut-through
//
// Functional notes
// - Ingress and egress limiting enabled separately
// - Rate above link speed means unlimited
// - Ingress rate set per priority
// - Egress rate set per output queue
// - Charge DA to FCS, optional gap/preamble
// - Ingress counts only selected frame class
// - Over ingress limit, drop further packets
// - Leaky bucket stretches gap per queue
// - Memory exhausted triggers drop or flow control
// - Credit shaper only on allowed top queues
// - Best-effort queues strict priority, no shaper
// - Waiting shaped queue earns credit, spends later
// - Unused reserved bandwidth goes to others
// - One gated queue, one or two shaped
// - Guard band starts only frames that fit
// - Window follows guard; only gated queue sends
// - After window non-gated queues scheduled normally; gated queue waits for next window
// - 128-entry interval table, several cycle sets
// - Cut-through enabled per port, gated queue
// - Cut-through only when all conditions hold
// - Cut-through starts after 64 bytes
// - Strict priority, queue 3 highest
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module esr_egress_shaping_rate_limiter (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_valid_in,
    input wire logic [13:0] rx_len_in,
    input wire logic [1:0] rx_prio_in,
    input wire logic [1:0] rx_kind_in,
    output logic [3:0] rx_drop_out,
    input wire logic [3:0] q_ready_in,
    input wire logic [55:0] q_len_in,
    input wire logic tx_done_in,
    output logic tx_start_out,
    output logic [1:0] tx_queue_out,
    input wire logic mem_full_in,
    output logic flow_ctrl_out,
    output logic congest_drop_out,
    input wire logic [31:0] time_in,
    input wire logic ct_req_in,
    input wire logic ct_unicast_in,
    input wire logic ct_sched_in,
    input wire logic ct_speed_ok_in,
    input wire logic [13:0] ct_bytes_in,
    output logic ct_go_out,
    output logic gate_open_out
);
    ////////////////////////////////////////////////////////////////////
    logic [20:0] ctrl_ff;
    logic [31:0] irate_ff;
    logic [31:0] erate_ff;
    logic [15:0] slope_ff;
    logic [6:0] tidx_ff;
    logic [31:0] tbl [0:127];
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] tick_ff;
    logic tick;
    logic tx_act_ff;
    logic tx_start_ff;
    logic [1:0] txq_ff;
    logic [1:0] rr_ff;
    logic [3:0] drop_ff;
    logic fc_ff;
    logic cd_ff;
    logic ct_pend_ff;
    logic ct_go_ff;
    logic gate_open_ff;
    logic [31:0] cs_ff;
    logic [31:0] rem_ff;
    esr_pkg::esr_gate_type gate_ff;
    esr_pkg::esr_gate_type nxt_gate;
    logic signed [20:0] ib_ff [4];
    logic signed [20:0] eb_ff [4];
    logic signed [20:0] cr_ff [4];
    logic [3:0] elig;
    logic [3:0] cbs_on;
    logic [1:0] pick;
    logic start_now;
    logic ct_ok;
    logic wr;
    logic gen;
    logic [1:0] gq;
    logic [7:0] lim;
    logic [6:0] base;
    logic [31:0] per;
    logic [31:0] phase;
    logic [31:0] ws;
    logic [31:0] gs;

    function automatic logic [14:0] esr_bytes(input logic [13:0] len,
                                              input logic [20:0] c);
        logic [14:0] b;
        b = {1'b0, len};
        if (c[esr_pkg::C_IFG])
            b = b + esr_pkg::IFG_BYTES;
        if (c[esr_pkg::C_PRE])
            b = b + esr_pkg::PRE_BYTES;
        return b;
    endfunction

    function automatic logic [1:0] esr_pick(input logic [3:0] e,
                                            input logic [1:0] st);
        logic [1:0] r;
        logic [1:0] k;
        r = st;
        for (int i = 3; i >= 0; i--)
        begin
            k = st - 2'(i);
            if (e[k])
                r = k;
        end
        return r;
    endfunction

    function automatic logic signed [20:0] esr_clamp(
        input logic signed [22:0] v);
        if (v > 23'(esr_pkg::BKT_CAP))
            return esr_pkg::BKT_CAP;
        else if (v < -23'(esr_pkg::BKT_CAP))
            return -esr_pkg::BKT_CAP;
        return 21'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, answer in the access cycle
    assign wr = psel_in && penable_in && pready_ff && pwrite_in;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= psel_in && !penable_in;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            if (psel_in && !penable_in)
            begin
                if (paddr_in == esr_pkg::A_CTRL)
                    prdata_ff <= 32'(ctrl_ff);
                else if (paddr_in == esr_pkg::A_IRATE)
                    prdata_ff <= irate_ff;
                else if (paddr_in == esr_pkg::A_ERATE)
                    prdata_ff <= erate_ff;
                else if (paddr_in == esr_pkg::A_SLOPE)
                    prdata_ff <= 32'(slope_ff);
                else if (paddr_in == esr_pkg::A_TIDX)
                    prdata_ff <= 32'(tidx_ff);
                else if (paddr_in == esr_pkg::A_TDATA)
                    prdata_ff <= tbl[tidx_ff];
                else if (paddr_in == esr_pkg::A_STAT)
                    prdata_ff <= 32'({gate_ff, ct_pend_ff, tx_act_ff,
                                      drop_ff});
                else
                    pslverr_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_ff <= esr_pkg::CTRL_RST;
            irate_ff <= 32'h00000000;
            erate_ff <= 32'h00000000;
            slope_ff <= 16'h0000;
            tidx_ff <= 7'h00;
        end
        else if (wr)
        begin
            if (paddr_in == esr_pkg::A_CTRL)
                ctrl_ff <= pwdata_in[20:0];
            else if (paddr_in == esr_pkg::A_IRATE)
                irate_ff <= pwdata_in;
            else if (paddr_in == esr_pkg::A_ERATE)
                erate_ff <= pwdata_in;
            else if (paddr_in == esr_pkg::A_SLOPE)
                slope_ff <= pwdata_in[15:0];
            else if (paddr_in == esr_pkg::A_TIDX)
                tidx_ff <= pwdata_in[6:0];
        end
    end

    // Interval table; no reset so it maps onto plain storage
    always_ff @(posedge clk_in)
    begin
        if (wr && paddr_in == esr_pkg::A_TDATA)
            tbl[tidx_ff] <= pwdata_in;
    end

    ////////////////////////////////////////////////////////////////////
    // Rate tick every microsecond; rates are in Mb/s, buckets in bits
    assign tick = (tick_ff == esr_pkg::TICK_CYC - 8'h01);
    assign lim = ctrl_ff[esr_pkg::C_S100] ? esr_pkg::LIM100 : esr_pkg::LIM10;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            tick_ff <= 8'h00;
        else if (tick)
            tick_ff <= 8'h00;
        else
            tick_ff <= tick_ff + 8'h01;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_q
            logic [7:0] ir;
            logic [7:0] er;
            logic ichg;
            logic echg;
            logic [17:0] ibits;
            logic [17:0] ebits;
            assign ir = irate_ff[8*g +: 8];
            assign er = erate_ff[8*g +: 8];
            assign ichg = rx_valid_in && rx_prio_in == 2'(g)
                && (ctrl_ff[esr_pkg::C_CLS +: 2] == esr_pkg::K_ALL
                || ctrl_ff[esr_pkg::C_CLS +: 2] == rx_kind_in);
            assign echg = start_now && pick == 2'(g);
            assign ibits = {esr_bytes(rx_len_in, ctrl_ff), 3'h0};
            assign ebits = {esr_bytes(q_len_in[14*g +: 14], ctrl_ff),
                            3'h0};

            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    ib_ff[g] <= esr_pkg::BKT_CAP;
                else if (!ctrl_ff[esr_pkg::C_IEN] || ir > lim)
                    ib_ff[g] <= esr_pkg::BKT_CAP;
                else
                    ib_ff[g] <= esr_clamp(23'(ib_ff[g])
                        + (tick ? 23'(ir) : 23'h0)
                        - (ichg ? 23'(ibits) : 23'h0));
            end

            // Charging each frame up front stretches the following gap
            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    eb_ff[g] <= esr_pkg::BKT_CAP;
                else if (!ctrl_ff[esr_pkg::C_EEN] || er > lim)
                    eb_ff[g] <= esr_pkg::BKT_CAP;
                else
                    eb_ff[g] <= esr_clamp(23'(eb_ff[g])
                        + (tick ? 23'(er) : 23'h0)
                        - (echg ? 23'(ebits) : 23'h0));
            end

            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    cr_ff[g] <= 21'sh000000;
                else if (!cbs_on[g])
                    cr_ff[g] <= 21'sh000000;
                else if (echg)
                    cr_ff[g] <= esr_clamp(23'(cr_ff[g]) - 23'(ebits));
                else if (tick && q_ready_in[g])
                    cr_ff[g] <= esr_clamp(23'(cr_ff[g])
                        + 23'(slope_ff));
                else if (!q_ready_in[g] && cr_ff[g] > 21'sh000000)
                    cr_ff[g] <= 21'sh000000;
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            drop_ff <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
                drop_ff[i] <= ib_ff[i] < 21'sh000000;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            fc_ff <= 1'b0;
            cd_ff <= 1'b0;
        end
        else
        begin
            fc_ff <= mem_full_in && ctrl_ff[esr_pkg::C_FC];
            cd_ff <= mem_full_in && !ctrl_ff[esr_pkg::C_FC];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gate timing against the shared time base
    assign gen = ctrl_ff[esr_pkg::C_GEN];
    assign gq = ctrl_ff[esr_pkg::C_GQ +: 2];
    assign base = {ctrl_ff[esr_pkg::C_SET +: 5], 2'h0};
    assign per = tbl[base | 7'(esr_pkg::E_PER)];
    assign phase = time_in - cs_ff;
    assign ws = per - tbl[base | 7'(esr_pkg::E_WIN)];
    assign gs = ws - tbl[base | 7'(esr_pkg::E_GRD)];

    always_comb
    begin
        nxt_gate = esr_pkg::G_OPEN;
        if (!gen || per == 32'h00000000)
            nxt_gate = esr_pkg::G_OPEN;
        else if (phase >= ws && phase < per)
            nxt_gate = esr_pkg::G_WIN;
        else if (phase >= gs && phase < ws)
            nxt_gate = esr_pkg::G_GUARD;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cs_ff <= 32'h00000000;
            gate_ff <= esr_pkg::G_OPEN;
            gate_open_ff <= 1'b0;
            rem_ff <= 32'h00000000;
        end
        else
        begin
            gate_ff <= nxt_gate;
            gate_open_ff <= nxt_gate == esr_pkg::G_WIN;
            rem_ff <= ws - phase;
            if (!gen)
                cs_ff <= time_in;
            else if (per != 32'h00000000 && phase >= per)
                cs_ff <= cs_ff + per;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Queue eligibility and selection
    always_comb
    begin
        for (int q = 0; q < 4; q++)
        begin
            if (ctrl_ff[esr_pkg::C_FOURQ])
                cbs_on[q] = q >= 2 && ctrl_ff[esr_pkg::C_CBS + q - 2];
            else
                cbs_on[q] = q == 1 && ctrl_ff[esr_pkg::C_CBS];
        end
    end

    always_comb
    begin
        logic [31:0] fns;
        logic [9:0] bns;
        fns = 32'h00000000;
        bns = ctrl_ff[esr_pkg::C_S100] ? esr_pkg::BYTE_NS_100
                                       : esr_pkg::BYTE_NS_10;
        for (int q = 0; q < 4; q++)
        begin
            fns = 32'(esr_bytes(q_len_in[14*q +: 14], ctrl_ff) * bns);
            elig[q] = q_ready_in[q] && (ctrl_ff[esr_pkg::C_FOURQ] || q < 2)
                && eb_ff[q] >= 21'sh000000
                && (!cbs_on[q] || cr_ff[q] >= 21'sh000000);
            case (gate_ff)
                esr_pkg::G_WIN:
                    elig[q] = elig[q] && 2'(q) == gq;
                esr_pkg::G_GUARD:
                    elig[q] = elig[q] && 2'(q) != gq
                        && fns < rem_ff;
                default:
                    elig[q] = elig[q] && !(gen && 2'(q) == gq);
            endcase
        end
    end

    // Rotation uses equal weights; strict mode starts from queue 3
    assign pick = esr_pick(elig, ctrl_ff[esr_pkg::C_WRR] ? rr_ff
                                                         : 2'h3);
    assign ct_ok = ctrl_ff[esr_pkg::C_CT] && gen && ct_unicast_in
        && ct_sched_in && gate_ff == esr_pkg::G_WIN && !tx_act_ff
        && !q_ready_in[gq] && ct_speed_ok_in;
    // A cut-through launch marks the port busy one edge late; hold off here
    assign start_now = !tx_act_ff && !ct_go_ff && |elig
        && !(ct_pend_ff && ct_ok);

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_act_ff <= 1'b0;
            tx_start_ff <= 1'b0;
            txq_ff <= 2'h0;
            rr_ff <= 2'h3;
        end
        else
        begin
            tx_start_ff <= start_now;
            if (start_now)
            begin
                txq_ff <= pick;
                rr_ff <= pick - 2'h1;
            end
            if (start_now || ct_go_ff)
                tx_act_ff <= 1'b1;
            else if (tx_done_in)
                tx_act_ff <= 1'b0;
        end
    end

    // Cut-through: qualify on request, launch once 64 bytes are in
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ct_pend_ff <= 1'b0;
            ct_go_ff <= 1'b0;
        end
        else
        begin
            ct_go_ff <= 1'b0;
            if (!ct_ok)
                ct_pend_ff <= 1'b0;
            else if (ct_pend_ff && ct_bytes_in >= esr_pkg::CT_BYTES)
            begin
                ct_pend_ff <= 1'b0;
                ct_go_ff <= 1'b1;
            end
            else if (ct_req_in)
                ct_pend_ff <= 1'b1;
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign rx_drop_out = drop_ff;
    assign tx_start_out = tx_start_ff;
    assign tx_queue_out = txq_ff;
    assign flow_ctrl_out = fc_ff;
    assign congest_drop_out = cd_ff;
    assign ct_go_out = ct_go_ff;
    assign gate_open_out = gate_open_ff;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_start_idle: assert property (
        tx_start_out |-> !$past(tx_act_ff))
        else $error("start while port busy");
    chk_win_gated: assert property (
        tx_start_out && $past(gate_ff == esr_pkg::G_WIN)
        |-> tx_queue_out == $past(gq))
        else $error("non-gated queue in window");
    chk_guard_fit: assert property (
        tx_start_out && $past(gate_ff == esr_pkg::G_GUARD)
        |-> tx_queue_out != $past(gq))
        else $error("gated queue in guard band");
    chk_strict_order: assert property (
        tx_start_out && !$past(ctrl_ff[esr_pkg::C_WRR])
        |-> ($past(elig) >> (3'(tx_queue_out) + 3'h1)) == 4'h0)
        else $error("higher queue skipped");
    chk_ct_bytes: assert property (
        ct_go_out |-> $past(ct_bytes_in) >= esr_pkg::CT_BYTES)
        else $error("cut-through before 64 bytes");
    chk_ct_window: assert property (
        ct_go_out |-> $past(gate_ff == esr_pkg::G_WIN && !tx_act_ff))
        else $error("cut-through outside window");
    chk_flow_ctrl: assert property (
        mem_full_in && ctrl_ff[esr_pkg::C_FC] |=> flow_ctrl_out)
        else $error("no flow control on full");
    chk_unlimited: assert property (
        !ctrl_ff[esr_pkg::C_S100] && irate_ff[15:8] > esr_pkg::LIM10
        ##1 $stable(ctrl_ff) && $stable(irate_ff) |=> !rx_drop_out[1])
        else $error("unlimited rate dropped");
    chk_start_gap: assert property (
        tx_start_out |=> !tx_start_out ##0 tx_act_ff)
        else $error("back to back starts");
    cov_window: cover property (gate_ff == esr_pkg::G_GUARD
        ##1 gate_ff == esr_pkg::G_WIN);
    cov_ct: cover property (ct_go_out);
    cov_drop: cover property (rx_drop_out != 4'h0);
    cov_wrr: cover property (tx_start_out && ctrl_ff[esr_pkg::C_WRR]);
endmodule

// [testbench/esr_mac_model.sv]
// Transmit MAC model that answers each start or cut-through launch taken while idle with a done pulse
`timescale 1ns/1ps
module esr_mac_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tx_start_in,
    input wire logic ct_go_in,
    input wire logic [7:0] lat_in,
    output logic tx_done_out
);
    logic [7:0] cnt_ff;
    logic busy_ff;
    ////////////////////////////////////////////////////////////////////
    // A start seen while busy is ignored, as a real MAC would drop it
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            tx_done_out <= 1'b0;
        end
        else
        begin
            tx_done_out <= 1'b0;
            if (!busy_ff && (tx_start_in || ct_go_in))
            begin
                busy_ff <= 1'b1;
                cnt_ff <= lat_in;
            end
            else if (busy_ff && cnt_ff == 8'h00)
            begin
                busy_ff <= 1'b0;
                tx_done_out <= 1'b1;
            end
            else if (busy_ff)
                cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule

// [testbench/esr_egress_shaping_rate_limiter_bench.sv]
// Self-checking bench for the shaping and rate limiting block
`timescale 1ns/1ps
module esr_egress_shaping_rate_limiter_bench;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, rx_valid = 1'b0, tx_done, mem_full = 1'b0;
    logic [7:0] paddr = 8'h00, lat = 8'h05;
    logic [31:0] pwdata = 32'h0, prdata, time_ns = 32'h0, rdv;
    logic pready, pslverr, tx_start, flow, cdrop, ct_go, gate_open, erv;
    logic [13:0] rx_len = 14'h05DC, ct_bytes = 14'h0000;
    logic [1:0] rx_prio = 2'h0, rx_kind = 2'h0, tx_queue;
    logic [3:0] rx_drop, q_ready = 4'h0;
    logic ct_req = 1'b0, ct_uni = 1'b0, ct_sch = 1'b0, ct_spd = 1'b0;
    logic busy = 1'b0;
    int mismatches = 0, comparisons = 0, open_cyc = 0, starts = 0;
    esr_egress_shaping_rate_limiter esr_egress_shaping_rate_limiter_i (
        .clk_in(clk), .resetn_in(resetn), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .rx_valid_in(rx_valid), .rx_len_in(rx_len),
        .rx_prio_in(rx_prio), .rx_kind_in(rx_kind), .rx_drop_out(rx_drop),
        .q_ready_in(q_ready),
        .q_len_in({14'h05DC, 14'h05DC, 14'h05DC, 14'h0040}),
        .tx_done_in(tx_done), .tx_start_out(tx_start),
        .tx_queue_out(tx_queue), .mem_full_in(mem_full),
        .flow_ctrl_out(flow), .congest_drop_out(cdrop), .time_in(time_ns),
        .ct_req_in(ct_req), .ct_unicast_in(ct_uni), .ct_sched_in(ct_sch),
        .ct_speed_ok_in(ct_spd), .ct_bytes_in(ct_bytes),
        .ct_go_out(ct_go), .gate_open_out(gate_open)
    );
    esr_mac_model esr_mac_model_i (
        .clk_in(clk), .resetn_in(resetn), .tx_start_in(tx_start),
        .lat_in(lat), .ct_go_in(ct_go), .tx_done_out(tx_done)
    );
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        time_ns <= time_ns + 32'h4;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Starts are only legal when idle; in the window only queue 0
    always @(posedge clk)
    begin
        if (tx_start === 1'b1)
        begin
            chk(busy, 1'b0);
            if (gate_open === 1'b1)
                chk(tx_queue, 2'h0);
        end
        if (gate_open === 1'b1)
            open_cyc++;
        if (tx_done === 1'b1)
            busy = 1'b0;
        if (tx_start === 1'b1 || ct_go === 1'b1)
            busy = 1'b1;
        if (tx_start === 1'b1)
            starts++;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk(n, 0);
    endtask
    task automatic frames(input logic [1:0] p, input logic [1:0] k);
        repeat (12)
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_prio <= p;
            rx_kind <= k;
            @(posedge clk);
            rx_valid <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_start(input logic [1:0] q);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (tx_start !== 1'b1 && n < 100);
        chk(tx_start, 1'b1);
        chk(tx_queue, q);
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_regs;
        apb(1'b0, esr_pkg::A_CTRL, 32'h0);
        chk(rdv, 32'(esr_pkg::CTRL_RST));
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        chk(erv, 1'b1);
        apb(1'b0, 8'h1C, 32'h0);
        chk(erv, 1'b1);
        chk(rdv, 32'h0);
        apb(1'b1, esr_pkg::A_CTRL, 32'h00004280);
        apb(1'b0, esr_pkg::A_CTRL, 32'h0);
        chk(rdv, 32'h00004280);
        apb(1'b1, esr_pkg::A_CTRL, 32'h0);
    endtask
    task t_prio;
        apb(1'b1, esr_pkg::A_CTRL, 32'h00000080);
        lat <= 8'h14;
        q_ready <= 4'h1;
        wait_start(2'h0);
        q_ready <= 4'h3;
        wait_start(2'h1);
        q_ready <= 4'h6;
        wait_start(2'h2);
        q_ready <= 4'hF;
        wait_start(2'h3);
        q_ready <= 4'h0;
        lat <= 8'h05;
        repeat (40) @(posedge clk);
    endtask
    task t_erate;
        // Queue 3 at 1 Mb/s: a full bucket pays for six 1500-byte frames
        apb(1'b1, esr_pkg::A_ERATE, 32'h01000000);
        apb(1'b1, esr_pkg::A_CTRL, 32'h00000082);
        starts = 0;
        q_ready <= 4'h8;
        repeat (150) @(posedge clk);
        chk(starts, 6);
        q_ready <= 4'h0;
        apb(1'b1, esr_pkg::A_CTRL, 32'h0);
    endtask
    task t_mem;
        apb(1'b1, esr_pkg::A_CTRL, 32'h00100000);
        mem_full <= 1'b1;
        repeat (3) @(posedge clk);
        chk({flow, cdrop}, 2'h2);
        apb(1'b1, esr_pkg::A_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk({flow, cdrop}, 2'h1);
        mem_full <= 1'b0;
        repeat (3) @(posedge clk);
        chk({flow, cdrop}, 2'h0);
    endtask
    task t_ingress;
        // Priorities 1 and 3 above the 10 Mb/s link rate: unlimited
        apb(1'b1, esr_pkg::A_IRATE, 32'hFF01FF01);
        apb(1'b1, esr_pkg::A_CTRL, 32'h00000001);
        frames(2'h1, 2'h0);
        frames(2'h0, 2'h0);
        chk(rx_drop, 4'h1);
        apb(1'b1, esr_pkg::A_CTRL, 32'h00000041);
        frames(2'h2, 2'h1);
        chk(rx_drop[2], 1'b0);
        apb(1'b1, esr_pkg::A_CTRL, 32'h0);
    endtask
    task t_gate;
        apb(1'b1, esr_pkg::A_TIDX, 32'h0);
        apb(1'b1, esr_pkg::A_TDATA, 32'h000007D0);
        apb(1'b1, esr_pkg::A_TIDX, 32'h1);
        apb(1'b1, esr_pkg::A_TDATA, 32'h000000C8);
        apb(1'b1, esr_pkg::A_TIDX, 32'h2);
        apb(1'b1, esr_pkg::A_TDATA, 32'h00000190);
        q_ready <= 4'hF;
        apb(1'b1, esr_pkg::A_CTRL, 32'h00000280);
        open_cyc = 0;
        repeat (1500) @(posedge clk);
        chk(open_cyc >= 295 && open_cyc <= 305, 1'b1);
        q_ready <= 4'h0;
    endtask
    task automatic ct_try(input logic [2:0] c, input logic e);
        logic seen;
        seen = 1'b0;
        {ct_uni, ct_sch, ct_spd} <= c;
        ct_bytes <= 14'h003F;
        ct_req <= 1'b1;
        @(posedge clk);
        ct_req <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            seen = seen | (ct_go === 1'b1);
        end
        chk(seen, 1'b0);
        ct_bytes <= esr_pkg::CT_BYTES;
        repeat (3)
        begin
            @(posedge clk);
            seen = seen | (ct_go === 1'b1);
        end
        chk(seen, e);
        ct_bytes <= 14'h0000;
    endtask
    task t_ct;
        int n;
        n = 0;
        apb(1'b1, esr_pkg::A_CTRL, 32'h00004280);
        while (gate_open !== 1'b0 && n < 1000) @(posedge clk) n++;
        while (gate_open !== 1'b1 && n < 1000) @(posedge clk) n++;
        chk(gate_open, 1'b1);
        repeat (3) @(posedge clk);
        ct_try(3'h3, 1'b0);
        ct_try(3'h5, 1'b0);
        ct_try(3'h6, 1'b0);
        ct_try(3'h7, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_prio();
        t_erate();
        t_mem();
        t_ingress();
        t_gate();
        t_ct();
        conclude();
    end
endmodule
